// *** logic/pcsl_defs.svh ***
// Operation
// R1 - Generated clock equals reference times m/(n*k); m,k 2..160, n 1..16.
// R2 - Generated clock phase shifts in 90 degree steps.
// R3 - Generated clock delay adjusts up or down, at most one period.
// R4 - Each loop drives its own lock indicator high once locked.
// R5 - Lock pin optional; unused, it serves as a general-purpose pin.
// R6 - Reference ignored until configuration done; acquisition starts then.
// R7 - Lock asserted within 40 us of acquisition start, given good reference.
// R8 - Lock limit is 40 us or 2000 reference cycles, whichever first.
// R9 - With acquire enable used, acquisition starts only when it goes high.
// R10 - Up to four independent loops; smallest part has two.
// R11 - Two loops support serial mode, multiplying the forwarded clock.
// R12 - Generated clock may drive off-chip; feedback may return off-chip.
// R13 - Configurer keeps oscillator between 200 and 500 MHz.
// R14 - Configurer keeps first output 1.5 to 335 MHz, or 200 MHz.
// R15 - Configurer keeps second output at least 20 MHz, same upper limits.
// R16 - Lock low in reset, configuration, disable; reasserts after new lock.
`ifndef PCSL_DEFS_SVH
`define PCSL_DEFS_SVH
`define PCSL_CLK_PERIOD_NS 100
`define PCSL_LOCK_TIME_NS 40000
`define PCSL_LOCK_CYC ((`PCSL_LOCK_TIME_NS) / (`PCSL_CLK_PERIOD_NS))
`define PCSL_LOCK_REF_CYC 2000
`define PCSL_LOCK_STABLE 3
`define PCSL_FB_SLACK 8
`define PCSL_MK_MIN 8'h02
`define PCSL_MK_MAX 8'ha0
`define PCSL_N_MIN 5'h01
`define PCSL_N_MAX 5'h10
`define PCSL_OFF_RATIO 2'h0
`define PCSL_OFF_CTRL 2'h1
`define PCSL_OFF_STAT 2'h2
`define PCSL_OFF_IRQ 8'h40
`define PCSL_OFF_MASK 8'h44
`define PCSL_OFF_INFO 8'h48
`define PCSL_RATIO_RST 32'h00010202
`define PCSL_CTRL_RST 32'h00000000
`define PCSL_CTRL_MASK 32'h0000ffff
`define PCSL_F_M_LSB 0
`define PCSL_F_K_LSB 8
`define PCSL_F_N_LSB 16
`define PCSL_B_EN 0
`define PCSL_F_PH_LSB 1
`define PCSL_B_LOCKPIN 3
`define PCSL_B_EXTOUT 4
`define PCSL_B_FBEXT 5
`define PCSL_B_SERIAL 6
`define PCSL_B_USEACQ 7
`define PCSL_F_DLY_LSB 8
`define PCSL_RESP_OKAY 2'h0
`define PCSL_RESP_SLVERR 2'h2
`endif

// *** logic/pcsl_pkg.sv ***
`default_nettype none
package pcsl_pkg;
	typedef enum logic [2:0] {
		PCSL_IDLE = 3'b001,
		PCSL_ACQ = 3'b010,
		PCSL_LOCKED = 3'b100
	} pcsl_lock_e;
	typedef struct packed {
		logic loop_hit;
		logic [1:0] idx;
		logic [1:0] sel;
		logic irq_hit;
		logic mask_hit;
		logic info_hit;
	} pcsl_dec_s;
endpackage : pcsl_pkg
`default_nettype wire

// *** logic/pcsl_loop.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pcsl_defs.svh"
module pcsl_loop #(
	parameter int PW = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ref_s,
	input wire logic fb_s,
	input wire logic run,
	input wire logic fb_ext,
	input wire logic [7:0] m_i,
	input wire logic [7:0] k_i,
	input wire logic [4:0] n_i,
	input wire logic [1:0] phase_i,
	output logic gen_clk,
	output logic locked,
	output logic acquiring,
	output logic gain_p,
	output logic loss_p,
	output logic [PW-1:0] ref_per,
	output logic [PW-1:0] out_per
);
	pcsl_pkg::pcsl_lock_e st_q, st_d;
	logic ref_d_q, fb_d_q, gen_d_q;
	logic [PW-1:0] cnt_q, per_q, ocnt_q, oper_q, fage_q;
	logic [11:0] time_q, edges_q;
	logic [2:0] stab_q;
	logic [28:0] acc_q;
	logic [1:0] quad_q;
	wire ref_rise = ref_s & ~ref_d_q;
	wire fb_rise = fb_s & ~fb_d_q;
	wire gen_rise = gen_clk & ~gen_d_q;
	wire [PW-1:0] cnt_inc = (&cnt_q) ? cnt_q : cnt_q + 1'b1;
	wire [PW-1:0] diff = (per_q > cnt_q) ? per_q - cnt_q : cnt_q - per_q;
	wire has_per = per_q != '0;
	wire stable_now = ref_rise && has_per && diff <= 1;
	wire ref_lost = has_per && {1'b0, cnt_q} > {per_q, 1'b0};
	wire [PW+1:0] fb_lim = {1'b0, oper_q, 1'b0} + (PW+2)'(`PCSL_FB_SLACK);
	wire fb_ok = !fb_ext || {2'b00, fage_q} <= fb_lim;
	wire limit = time_q >= 12'(`PCSL_LOCK_CYC - 1) ||
		edges_q >= 12'(`PCSL_LOCK_REF_CYC); // R8
	wire lock_ok = (stab_q >= 3'(`PCSL_LOCK_STABLE) && fb_ok) ||
		(limit && has_per && !ref_lost); // R7
	wire drop = !run;
	wire slip = (ref_rise && !stable_now) || ref_lost || !fb_ok; // R16
	// Synthesis: 4m quarter ticks per n*k reference periods
	wire [12:0] nk = 13'(n_i) * 13'(k_i);
	wire [28:0] span = 29'(per_q) * 29'(nk); // R1
	wire [29:0] acc_sum = {1'b0, acc_q} + {20'h0, m_i, 2'b00};
	wire wrap = acc_sum >= {1'b0, span};
	wire synth_on = st_q != pcsl_pkg::PCSL_IDLE && span != '0;
	wire [1:0] quad_d = quad_q + 2'(wrap);
	wire [1:0] shifted = quad_d + phase_i; // R2
	always_comb begin
		st_d = st_q;
		case (st_q)
			pcsl_pkg::PCSL_IDLE: if (run) st_d = pcsl_pkg::PCSL_ACQ; // R6 R9
			pcsl_pkg::PCSL_ACQ: begin
				if (drop) st_d = pcsl_pkg::PCSL_IDLE;
				else if (lock_ok) st_d = pcsl_pkg::PCSL_LOCKED; // R4
			end
			pcsl_pkg::PCSL_LOCKED: begin
				if (drop) st_d = pcsl_pkg::PCSL_IDLE; // R16
				else if (slip) st_d = pcsl_pkg::PCSL_ACQ;
			end
			default: st_d = pcsl_pkg::PCSL_IDLE;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= pcsl_pkg::PCSL_IDLE;
			ref_d_q <= 1'b0;
			fb_d_q <= 1'b0;
			gen_d_q <= 1'b0;
			cnt_q <= '0;
			per_q <= '0;
			time_q <= '0;
			edges_q <= '0;
			stab_q <= '0;
			fage_q <= '1;
			gain_p <= 1'b0;
			loss_p <= 1'b0;
		end else begin
			st_q <= st_d;
			ref_d_q <= ref_s;
			fb_d_q <= fb_s;
			gen_d_q <= gen_clk;
			gain_p <= st_q != pcsl_pkg::PCSL_LOCKED &&
				st_d == pcsl_pkg::PCSL_LOCKED;
			loss_p <= st_q == pcsl_pkg::PCSL_LOCKED &&
				st_d != pcsl_pkg::PCSL_LOCKED;
			fage_q <= fb_rise ? '0 : ((&fage_q) ? fage_q : fage_q + 1'b1);
			if (st_q == pcsl_pkg::PCSL_IDLE) begin // R6
				cnt_q <= '0;
				per_q <= '0;
			end else if (ref_rise) begin
				cnt_q <= PW'(1);
				per_q <= cnt_q;
			end else begin
				cnt_q <= cnt_inc;
			end
			if (st_q != pcsl_pkg::PCSL_ACQ) begin
				time_q <= '0;
				edges_q <= '0;
				stab_q <= '0;
			end else begin
				time_q <= (&time_q) ? time_q : time_q + 1'b1;
				if (ref_rise) edges_q <= edges_q + 1'b1;
				if (ref_rise) stab_q <= stable_now ? 3'((stab_q == 3'h7) ?
					3'h7 : stab_q + 1'b1) : 3'h0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= '0;
			quad_q <= '0;
			gen_clk <= 1'b0;
			ocnt_q <= '0;
			oper_q <= '0;
		end else begin
			if (!synth_on || {1'b0, acc_q} >= {1'b0, span}) acc_q <= '0;
			else acc_q <= wrap ? 29'(acc_sum - {1'b0, span}) : acc_sum[28:0];
			quad_q <= synth_on ? quad_d : 2'h0;
			gen_clk <= synth_on ? shifted[1] : 1'b0;
			ocnt_q <= gen_rise ? PW'(1) : ((&ocnt_q) ? ocnt_q : ocnt_q + 1'b1);
			if (gen_rise) oper_q <= ocnt_q;
		end
	end
	assign locked = st_q == pcsl_pkg::PCSL_LOCKED;
	assign acquiring = st_q == pcsl_pkg::PCSL_ACQ;
	assign ref_per = per_q;
	assign out_per = oper_q;
endmodule : pcsl_loop
`default_nettype wire

// *** logic/pcsl_top.sv ***
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcsl_defs.svh"
module pcsl_top #(
	parameter int NUM_LOOPS = 4,
	parameter logic [3:0] SERIAL_CAP = 4'h3,
	parameter int DLY_DEPTH = 64,
	parameter int PW = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic config_done,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	input wire logic [NUM_LOOPS-1:0] ref_clk_pin,
	input wire logic [NUM_LOOPS-1:0] fb_clk_pin,
	input wire logic [NUM_LOOPS-1:0] loop_acquire_enable,
	input wire logic [NUM_LOOPS-1:0] lock_pin_i,
	output logic [NUM_LOOPS-1:0] lock_pin_o,
	output logic [NUM_LOOPS-1:0] lock_pin_oe,
	input wire logic [NUM_LOOPS-1:0] user_gpio_o,
	input wire logic [NUM_LOOPS-1:0] user_gpio_oe,
	output logic [NUM_LOOPS-1:0] user_gpio_in,
	output logic [NUM_LOOPS-1:0] core_clk,
	output logic [NUM_LOOPS-1:0] ext_clk_o,
	output logic [NUM_LOOPS-1:0] ext_clk_oe,
	output logic [NUM_LOOPS-1:0] bit_strobe,
	output logic [NUM_LOOPS-1:0] locked
);
	localparam int L2 = 2 * NUM_LOOPS;
	localparam int D0 = DLY_DEPTH / 2;
	localparam int DW = $clog2(DLY_DEPTH);

	function automatic pcsl_pkg::pcsl_dec_s dec(input logic [7:0] a);
		pcsl_pkg::pcsl_dec_s d;
		d.idx = a[5:4];
		d.sel = a[3:2];
		d.loop_hit = a[7:6] == 2'h0 && 32'(a[5:4]) < NUM_LOOPS &&
			a[3:2] != 2'h3;
		d.irq_hit = {a[7:2], 2'h0} == `PCSL_OFF_IRQ;
		d.mask_hit = {a[7:2], 2'h0} == `PCSL_OFF_MASK;
		d.info_hit = {a[7:2], 2'h0} == `PCSL_OFF_INFO;
		return d;
	endfunction : dec

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[8*b +: 8] = n[8*b +: 8];
		end
		return r;
	endfunction : merge

	function automatic logic [7:0] clamp_mk(input logic [7:0] v);
		return (v < `PCSL_MK_MIN) ? `PCSL_MK_MIN :
			((v > `PCSL_MK_MAX) ? `PCSL_MK_MAX : v);
	endfunction : clamp_mk

	function automatic logic [4:0] clamp_n(input logic [4:0] v);
		return (v < `PCSL_N_MIN) ? `PCSL_N_MIN :
			((v > `PCSL_N_MAX) ? `PCSL_N_MAX : v);
	endfunction : clamp_n

	// Write channel: address and data taken in either order
	logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
	logic arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	wire aw_hs = s_axi_awvalid & awready_q;
	wire w_hs = s_axi_wvalid & wready_q;
	wire do_wr = aw_have_q & w_have_q & ~bvalid_q;
	wire aw_have_d = (aw_have_q | aw_hs) & ~do_wr;
	wire w_have_d = (w_have_q | w_hs) & ~do_wr;
	wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready);
	wire ar_hs = s_axi_arvalid & arready_q;
	wire rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);
	pcsl_pkg::pcsl_dec_s wd, rd;
	assign wd = dec(waddr_q);
	assign rd = dec(s_axi_araddr);
	wire wd_hit = wd.loop_hit | wd.irq_hit | wd.mask_hit | wd.info_hit;
	wire rd_hit = rd.loop_hit | rd.irq_hit | rd.mask_hit | rd.info_hit;

	logic [31:0] ratio_q [NUM_LOOPS];
	logic [31:0] ctrl_q [NUM_LOOPS];
	logic [31:0] stat_w [NUM_LOOPS];
	logic [NUM_LOOPS-1:0] gain_w, loss_w;
	logic [L2-1:0] ist_q, imask_q;

	// Set beats write-one-to-clear in the same cycle
	wire s_axi_wstrb_ok = wstrb_q[0];
	wire clr_en = do_wr & wd.irq_hit & s_axi_wstrb_ok;
	wire [L2-1:0] ist_clr = clr_en ? wdata_q[L2-1:0] : '0;
	wire [L2-1:0] ist_d = {loss_w, gain_w} | (ist_q & ~ist_clr);
	wire [31:0] loop_rd = (rd.sel == `PCSL_OFF_RATIO) ? ratio_q[rd.idx] :
		((rd.sel == `PCSL_OFF_CTRL) ? ctrl_q[rd.idx] : stat_w[rd.idx]);
	wire [31:0] rd_val = rd.loop_hit ? loop_rd :
		(rd.irq_hit ? 32'(ist_q) : (rd.mask_hit ? 32'(imask_q) :
		(rd.info_hit ? 32'(NUM_LOOPS) : 32'h0)));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `PCSL_RESP_OKAY;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= ~aw_have_d & ~bvalid_d;
			wready_q <= ~w_have_d & ~bvalid_d;
			bvalid_q <= bvalid_d;
			if (aw_hs) waddr_q <= s_axi_awaddr;
			if (w_hs) wdata_q <= s_axi_wdata;
			if (w_hs) wstrb_q <= s_axi_wstrb;
			if (do_wr) bresp_q <= wd_hit ? `PCSL_RESP_OKAY : `PCSL_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `PCSL_RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_hs) rdata_q <= rd_val;
			if (ar_hs) rresp_q <= rd_hit ? `PCSL_RESP_OKAY : `PCSL_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_q <= '0;
			imask_q <= '0;
			irq <= 1'b0;
		end else begin
			ist_q <= ist_d;
			if (do_wr && wd.mask_hit && wstrb_q[0]) imask_q <= wdata_q[L2-1:0];
			irq <= |(ist_q & imask_q);
		end
	end

	// Pin synchronisers: ref, feedback, acquire enable, lock pin
	logic [4*NUM_LOOPS-1:0] sync_a_q, sync_b_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a_q <= '0;
			sync_b_q <= '0;
		end else begin
			sync_a_q <= {lock_pin_i, loop_acquire_enable, fb_clk_pin, ref_clk_pin};
			sync_b_q <= sync_a_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_LOOPS; i++) begin : g_loop // R10
			wire [31:0] ratio_wr = merge(ratio_q[i], wdata_q, wstrb_q);
			wire [31:0] ctrl_wr = merge(ctrl_q[i], wdata_q, wstrb_q);
			wire wr_this = do_wr && wd.loop_hit && 32'(wd.idx) == i;
			wire [31:0] c = ctrl_q[i];
			wire serial = c[`PCSL_B_SERIAL] & SERIAL_CAP[i]; // R11
			wire ref_s = sync_b_q[i];
			wire fb_s = sync_b_q[NUM_LOOPS + i];
			wire en_s = sync_b_q[2*NUM_LOOPS + i];
			wire pin_s = sync_b_q[3*NUM_LOOPS + i];
			wire run = config_done && c[`PCSL_B_EN] &&
				(!c[`PCSL_B_USEACQ] || en_s); // R6 R9
			wire [7:0] m = ratio_q[i][`PCSL_F_M_LSB +: 8];
			// Serial mode multiplies by m alone
			wire [7:0] k = serial ? 8'h01 : ratio_q[i][`PCSL_F_K_LSB +: 8];
			wire [4:0] n = serial ? 5'h01 : ratio_q[i][`PCSL_F_N_LSB +: 5];
			logic gen, lk, acq;
			logic [PW-1:0] rper, oper;
			logic [DLY_DEPTH-1:0] dly_q;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ratio_q[i] <= `PCSL_RATIO_RST;
					ctrl_q[i] <= `PCSL_CTRL_RST;
				end else if (wr_this && wd.sel == `PCSL_OFF_RATIO) begin
					ratio_q[i] <= {11'h0, clamp_n(ratio_wr[`PCSL_F_N_LSB +: 5]),
						clamp_mk(ratio_wr[`PCSL_F_K_LSB +: 8]),
						clamp_mk(ratio_wr[`PCSL_F_M_LSB +: 8])}; // R1
				end else if (wr_this && wd.sel == `PCSL_OFF_CTRL) begin
					ctrl_q[i] <= (ctrl_wr & `PCSL_CTRL_MASK) &
						~(32'(!SERIAL_CAP[i]) << `PCSL_B_SERIAL);
				end
			end
			pcsl_loop #(
				.PW(PW)
			) u_loop (
				.aclk(aclk),
				.aresetn(aresetn),
				.ref_s(ref_s),
				.fb_s(fb_s),
				.run(run),
				.fb_ext(c[`PCSL_B_FBEXT]), // R12
				.m_i(m),
				.k_i(k),
				.n_i(n),
				.phase_i(c[`PCSL_F_PH_LSB +: 2]),
				.gen_clk(gen),
				.locked(lk),
				.acquiring(acq),
				.gain_p(gain_w[i]),
				.loss_p(loss_w[i]),
				.ref_per(rper),
				.out_per(oper)
			);
			assign stat_w[i] = {rper, 14'h0, acq, lk};
			// Nominal delay D0 cycles; offset moves the tap either way
			wire [7:0] off = c[`PCSL_F_DLY_LSB +: 8];
			wire [7:0] mag = off[7] ? 8'(-off) : off;
			wire [7:0] lim = ({{(32-PW){1'b0}}, oper} < 32'(D0 - 1)) ?
				8'(oper) : 8'(D0 - 1);
			wire [7:0] mag_c = (mag > lim) ? lim : mag; // R3
			wire [DW-1:0] tap = off[7] ? DW'(D0 - 32'(mag_c)) :
				DW'(D0 + 32'(mag_c));
			logic [DW-1:0] tap_q;
			// Tap moves only where old and new taps match a settled
			// output, so a delay change never yields a short pulse
			wire tap_ok = dly_q[tap] == dly_q[tap_q] &&
				dly_q[tap_q] == core_clk[i];
			wire dly_out = dly_q[tap_q];
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					dly_q <= '0;
					tap_q <= DW'(D0);
					core_clk[i] <= 1'b0;
					ext_clk_o[i] <= 1'b0;
					ext_clk_oe[i] <= 1'b0;
					bit_strobe[i] <= 1'b0;
					locked[i] <= 1'b0;
					lock_pin_o[i] <= 1'b0;
					lock_pin_oe[i] <= 1'b0;
					user_gpio_in[i] <= 1'b0;
				end else begin
					dly_q <= {dly_q[DLY_DEPTH-2:0], gen};
					if (tap_ok) begin
						tap_q <= tap; // R3
					end
					core_clk[i] <= dly_out;
					ext_clk_o[i] <= dly_out & c[`PCSL_B_EXTOUT]; // R12
					ext_clk_oe[i] <= c[`PCSL_B_EXTOUT];
					bit_strobe[i] <= serial & dly_out & ~core_clk[i]; // R11
					locked[i] <= lk; // R4 R16
					lock_pin_o[i] <= c[`PCSL_B_LOCKPIN] ? lk : user_gpio_o[i]; // R5
					lock_pin_oe[i] <= c[`PCSL_B_LOCKPIN] | user_gpio_oe[i]; // R5
					user_gpio_in[i] <= pin_s;
				end
			end
		end
	endgenerate

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule : pcsl_top
`default_nettype wire

// *** test/pcsl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcsl_assertions #(
	parameter int NUM_LOOPS = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic config_done,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_LOOPS-1:0] lock_pin_i,
	input wire logic [NUM_LOOPS-1:0] user_gpio_in,
	input wire logic [NUM_LOOPS-1:0] core_clk,
	input wire logic [NUM_LOOPS-1:0] ext_clk_o,
	input wire logic [NUM_LOOPS-1:0] ext_clk_oe,
	input wire logic [NUM_LOOPS-1:0] bit_strobe,
	input wire logic [NUM_LOOPS-1:0] locked
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [2:0] age_q;
	// Synchroniser history is meaningless until it has refilled
	always_ff @(posedge aclk) begin
		age_q <= !aresetn ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
	end
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_ans;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence
	a_wr_walk: assert property (s_wr_take |=> s_wr_ans)
		else $error("write answer off schedule");
	a_rd_walk: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	a_cfg_lock: assert property (!config_done [*4] |-> locked == '0)
		else $error("lock without configuration");
	a_lock_cause: assert property ($rose(locked[0]) |->
		$past(config_done, 3)) else $error("lock rose too soon");
	a_gpio_lat: assert property (age_q == 3'h7 |->
		user_gpio_in == $past(lock_pin_i, 3)) else $error("gpio input lag");
	a_ext_gate: assert property ((ext_clk_o & ~ext_clk_oe) == '0)
		else $error("ext clock ungated");
	a_strobe_one: assert property ((bit_strobe & $past(bit_strobe)) == '0)
		else $error("strobe too long");
	a_serial_cap: assert property ((bit_strobe >> 2) == '0)
		else $error("strobe on plain loop");
	a_core_hold: assert property ($rose(core_clk[0]) |=> core_clk[0])
		else $error("core clock too fast");
endmodule : pcsl_assertions
`default_nettype wire

// *** test/pcsl_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcsl_board #(
	parameter int NL = 4
) (
	input wire logic aclk,
	input wire logic [NL-1:0] ref_run,
	input wire logic [NL-1:0] ext_clk_o,
	input wire logic [NL-1:0] ext_clk_oe,
	input wire logic [NL-1:0] lock_pin_o,
	input wire logic [NL-1:0] lock_pin_oe,
	input wire logic [NL-1:0] board_lvl,
	output logic [NL-1:0] ref_clk_pin,
	output logic [NL-1:0] fb_clk_pin,
	output logic [NL-1:0] lock_pin_i
);
	logic idle_q = 1'b0;
	// Undriven return toggles so a stale level never passes as a clock
	always @(posedge aclk) idle_q <= ~idle_q;
	for (genvar i = 0; i < NL; i++) begin : g_src
		logic osc = 1'b0;
		// Pulled source stands still, phase unrelated to aclk
		initial begin
			#(130 * i);
			forever #500 osc = ref_run[i] ? ~osc : 1'b0;
		end
		assign ref_clk_pin[i] = osc;
		assign fb_clk_pin[i] = ext_clk_oe[i] ? ext_clk_o[i] : idle_q;
		assign lock_pin_i[i] = lock_pin_oe[i] ? lock_pin_o[i] : board_lvl[i];
	end
endmodule : pcsl_board
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int NL = 4;
	localparam int LIM = 40000 / 100 + 12;
	logic aclk, aresetn, config_done, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, lf, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [NL-1:0] ref_clk_pin, fb_clk_pin, loop_acquire_enable, lock_pin_i;
	logic [NL-1:0] lock_pin_o, lock_pin_oe, user_gpio_o, user_gpio_oe;
	logic [NL-1:0] user_gpio_in, core_clk, ext_clk_o, ext_clk_oe;
	logic [NL-1:0] bit_strobe, locked, ref_run, board_lvl;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	logic [33:0] ex;
	int num_errors, tests_run, s, n;
	logic [31:0] rw[3] = '{32'h001f00ff, 32'h00000001, 32'h00080a05};
	logic [31:0] rx[3] = '{32'h001002a0, 32'h00010202, 32'h00080a05};
	logic [31:0] rt[3] = '{32'h00010202, 32'h00010204, 32'h00010402};
	int sp[3] = '{40, 20, 80};
	pcsl_top #(.NUM_LOOPS(NL)) dut (.aclk, .aresetn, .config_done,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .irq, .ref_clk_pin, .fb_clk_pin, .loop_acquire_enable,
		.lock_pin_i, .lock_pin_o, .lock_pin_oe, .user_gpio_o, .user_gpio_oe,
		.user_gpio_in, .core_clk, .ext_clk_o, .ext_clk_oe, .bit_strobe,
		.locked);
	pcsl_board #(.NL(NL)) board (.aclk, .ref_run, .ext_clk_o, .ext_clk_oe,
		.lock_pin_o, .lock_pin_oe, .board_lvl, .ref_clk_pin, .fb_clk_pin,
		.lock_pin_i);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task tmo;
		num_errors++;
		print_verdict;
	endtask : tmo
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int t;
		exp_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		t = 0;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && t < 50);
		if (t >= 50) tmo;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int t;
		exp_r.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		t = 0;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && t < 50);
		if (t >= 50) tmo;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic wait_lock(input int i, input int lim, input logic e);
		int t;
		t = 0;
		while (locked[i] !== e && t < lim) begin
			@(posedge aclk);
			t++;
		end
		if (t >= lim) tmo;
	endtask : wait_lock
	task automatic span(output int c);
		int t, e;
		logic p;
		c = 0;
		e = 0;
		t = 0;
		p = core_clk[0];
		while (e < 5 && t < 1000) begin
			@(posedge aclk);
			t++;
			if (e > 0) c++;
			if (core_clk[0] === 1'b1 && p === 1'b0) e++;
			p = core_clk[0];
		end
	endtask : span
	// Responses are judged here so drivers never wait on a compare
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0) begin
			ex = exp_r.pop_front();
			chk("rdata", ex[31:0], s_axi_rdata);
			chk("rresp", {30'h0, ex[33:32]}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0) begin
			chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
		end
	end
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		repeat (100000) @(posedge aclk);
		tmo;
	end
	initial begin
		{aresetn, config_done, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{loop_acquire_enable, user_gpio_o, user_gpio_oe, board_lvl} = '0;
		ref_run = '1;
		lf = 32'ha406;
		num_errors = 0;
		tests_run = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h48, 32'h4, 2'h0);
		rd(8'h00, 32'h00010202, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h4c, 32'h0, 2'h2);
		wr(8'h0c, 32'h1, 2'h2);
		for (int j = 0; j < 3; j++) begin
			wr(8'h10, rw[j], 2'h0);
			rd(8'h10, rx[j], 2'h0);
		end
		$display("test map done");
		wr(8'h44, 32'h0, 2'h0);
		wr(8'h04, 32'h19, 2'h0);
		repeat (LIM + 100) @(posedge aclk);
		chk("early lock", 32'h0, {28'h0, locked});
		config_done <= 1'b1;
		wait_lock(0, LIM, 1'b1);
		repeat (3) @(posedge aclk);
		chk("lock pin", 32'h3, {30'h0, lock_pin_oe[0], lock_pin_o[0]});
		chk("masked irq", 32'h0, {31'h0, irq});
		rd(8'h08, 32'h000a0001, 2'h0);
		wr(8'h44, 32'h1, 2'h0);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(8'h40, 32'h1, 2'h0);
		chk("irq off", 32'h0, {31'h0, irq});
		$display("test lock done");
		for (int j = 0; j < 3; j++) begin
			wr(8'h00, rt[j], 2'h0);
			repeat (60) @(posedge aclk);
			span(s);
			chk("out period", 32'h1, {31'h0, s >= sp[j] - 2 && s <= sp[j] + 2});
		end
		chk("ext oe", 32'h1, {31'h0, ext_clk_oe[0]});
		for (int ph = 0; ph < 4; ph++) begin
			lf = lfsr(lf);
			v = {16'h0, lf[7:0], 8'h19} | (ph << 1);
			wr(8'h04, v, 2'h0);
			rd(8'h04, v, 2'h0);
		end
		$display("test shift done");
		wr(8'h04, 32'h59, 2'h0);
		n = 0;
		repeat (200) begin
			@(posedge aclk);
			if (bit_strobe[0] === 1'b1) n++;
		end
		chk("strobes seen", 32'h1, {31'h0, n > 0});
		wr(8'h24, 32'h41, 2'h0);
		rd(8'h24, 32'h01, 2'h0);
		wr(8'h04, 32'h11, 2'h0);
		repeat (4) begin
			lf = lfsr(lf);
			user_gpio_o <= lf[3:0];
			user_gpio_oe <= lf[7:4];
			board_lvl <= lf[11:8];
			repeat (4) @(posedge aclk);
			chk("gpio out", {24'h0, user_gpio_oe, user_gpio_o},
				{24'h0, lock_pin_oe, lock_pin_o});
		end
		$display("test pins done");
		wr(8'h14, 32'h81, 2'h0);
		repeat (LIM + 50) @(posedge aclk);
		chk("gated loop", 32'h0, {31'h0, locked[1]});
		chk("other loop", 32'h1, {31'h0, locked[0]});
		loop_acquire_enable[1] <= 1'b1;
		wait_lock(1, LIM, 1'b1);
		wr(8'h44, 32'h20, 2'h0);
		ref_run[1] <= 1'b0;
		wait_lock(1, 80, 1'b0);
		repeat (4) @(posedge aclk);
		chk("loss irq", 32'h1, {31'h0, irq});
		wr(8'h40, 32'h20, 2'h0);
		chk("loss clear", 32'h0, {31'h0, irq});
		wr(8'h04, 32'h0, 2'h0);
		wait_lock(0, 8, 1'b0);
		$display("test loss done");
		print_verdict;
	end
endmodule : tb
bind pcsl_top pcsl_assertions #(.NUM_LOOPS(NUM_LOOPS)) u_chk (.aclk,
	.aresetn, .config_done, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.lock_pin_i, .user_gpio_in, .core_clk, .ext_clk_o, .ext_clk_oe,
	.bit_strobe, .locked);
`default_nettype wire
